// file: std_irq_prio_overrun.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Priority is three bits, low bit is parity
// R2 - Priority {upper, lower, parity}; zero is highest
// R3 - Channel I pair field in bits 1:0
// R4 - Pairs H,G,F,E at 7:6,5:4,3:2,1:0
// R5 - Priority fields changed only by software writes
// R6 - Priority registers reset to all ones
// R7 - Channel I overrun on edge while pending
// R8 - E0..H1 overrun on edge while pending
// R9 - Overrun registers read-only, reset to zero
// R10 - Channel registers at consecutive indices
// R11 - Edge sets pending, acknowledge clears, mask gates
// R12 - Edge select zero falling, one rising
// R13 - Winner code latched at arbitration start
// R14 - Overrun clears when pending clears, edge wins
module std_irq_prio_overrun #(
  parameter int unsigned NUM_CH = std_irq_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt lines, index 0..7 = E0..H1, 8 = I0
  input  wire logic [8:0]  int_lines,
  // CPU arbitration side
  input  wire logic        arbitration_cycle_start,
  input  wire logic        int_ack,
  output logic             int_request,
  output logic [3:0]       arb_winner,
  output logic             arb_valid,
  // Summary interrupt
  output logic             irq
);

  // The register map is fixed at nine channels; a wrong value is refused
  // while the design is elaborated, before any cycle can run
  if (NUM_CH != std_irq_pkg::NUM_CHANNELS) begin : g_bad_num_ch
    $error("NUM_CH must equal the nine channels of the register map");
  end

  // Software-held registers
  logic       mask_i;           // Channel I mask bit
  logic [7:0] mask_eh;          // Channel E..H mask bits
  logic       edge_i;           // Channel I edge select
  logic [7:0] edge_eh;          // Channel E..H edge selects
  logic [1:0] prio_i;           // Channel I pair priority field
  logic [7:0] prio_eh;          // Pairs E..H priority fields
  logic [2:0] vector_msb;       // Vector bits 7:5
  logic [8:0] irq_status;       // Sticky overrun events
  logic [8:0] irq_mask;         // Enables for irq_status

  // Channel state
  logic [8:0] pending;
  logic [8:0] overrun;
  logic [8:0] overrun_event;
  logic [8:0] ack_clear;
  logic [8:0] mask_all;
  logic [8:0] edge_all;

  // Data phase of the bus
  logic       dp_write;         // Write data phase under way
  logic [7:0] dp_index;         // Register index of that write
  logic       dp_mapped;        // Address fell in the register window
  logic [7:0] wbyte;            // Written byte

  // Write strobes, one per register
  logic       wr_mask_i;
  logic       wr_mask_eh;
  logic       wr_edge_i;
  logic       wr_edge_eh;
  logic       wr_pend_i;
  logic       wr_pend_eh;
  logic       wr_vector;
  logic       wr_prio_i;
  logic       wr_prio_eh;
  logic       wr_status;
  logic       wr_irq_mask;

  // Address phase
  logic       ap_take;          // A transfer is taken this cycle
  logic [7:0] ap_index;
  logic       ap_mapped;
  logic [7:0] rd_value;         // Read value of the addressed register

  // Arbitration
  logic [2:0] chan_prio [9];    // Full priority per channel
  logic [3:0] best_code;        // Current best requesting channel
  logic       best_valid;       // At least one request
  logic [2:0] best_prio;

  assign hreadyout = 1'b1;                        // Zero wait states
  assign hresp     = std_irq_pkg::HRESP_OKAY;
  assign mask_all  = {mask_i, mask_eh};
  assign edge_all  = {edge_i, edge_eh};
  assign wbyte     = hwdata[7:0];

  // Address phase decode; bits above the index window must be zero
  assign ap_take   = hsel && hready && (htrans == std_irq_pkg::HTRANS_NONSEQ);
  assign ap_index  = haddr[std_irq_pkg::IDX_MSB:std_irq_pkg::IDX_LSB];
  assign ap_mapped = (haddr[31:std_irq_pkg::IDX_MSB+1] == 22'h000000) && (haddr[1:0] == 2'h0);

  // Remember a write until its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_index  <= 8'h00;
      dp_mapped <= 1'b0;
    end else if (hready) begin
      dp_write  <= ap_take && hwrite;
      dp_index  <= ap_index;
      dp_mapped <= ap_mapped;
    end
  end

  // Write strobes; the overrun registers have none, so writes there are dropped
  always_comb begin
    wr_mask_i   = 1'b0;
    wr_mask_eh  = 1'b0;
    wr_edge_i   = 1'b0;
    wr_edge_eh  = 1'b0;
    wr_pend_i   = 1'b0;
    wr_pend_eh  = 1'b0;
    wr_vector   = 1'b0;
    wr_prio_i   = 1'b0;
    wr_prio_eh  = 1'b0;
    wr_status   = 1'b0;
    wr_irq_mask = 1'b0;
    if (dp_write && dp_mapped) begin
      case (dp_index)
        std_irq_pkg::IDX_CHAN_I_MASK:          wr_mask_i   = 1'b1;
        std_irq_pkg::IDX_CHAN_E_H_MASK:        wr_mask_eh  = 1'b1;
        std_irq_pkg::IDX_CHAN_I_EDGE_SELECT:   wr_edge_i   = 1'b1;
        std_irq_pkg::IDX_CHAN_E_H_EDGE_SELECT: wr_edge_eh  = 1'b1;
        std_irq_pkg::IDX_CHAN_I_PENDING:       wr_pend_i   = 1'b1;
        std_irq_pkg::IDX_CHAN_E_H_PENDING:     wr_pend_eh  = 1'b1;
        std_irq_pkg::IDX_VECTOR_AND_WINNER:    wr_vector   = 1'b1;
        std_irq_pkg::IDX_CHAN_I_PRIORITY:      wr_prio_i   = 1'b1;
        std_irq_pkg::IDX_CHAN_E_H_PRIORITY:    wr_prio_eh  = 1'b1;
        std_irq_pkg::IDX_IRQ_STATUS:           wr_status   = 1'b1;
        std_irq_pkg::IDX_IRQ_MASK:             wr_irq_mask = 1'b1;
        default: begin
          // Unmapped or read-only: write ignored
        end
      endcase
    end
  end

  // Mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_i  <= 1'b0;
      mask_eh <= std_irq_pkg::RST_ZERO;
    end else begin
      if (wr_mask_i) begin
        mask_i <= wbyte[0];
      end
      if (wr_mask_eh) begin
        mask_eh <= wbyte;
      end
    end
  end

  // Edge select registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_i  <= 1'b0;
      edge_eh <= std_irq_pkg::RST_ZERO;
    end else begin
      if (wr_edge_i) begin
        edge_i <= wbyte[0];
      end
      if (wr_edge_eh) begin
        edge_eh <= wbyte;
      end
    end
  end

  // Priority fields: only a bus write moves them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio_i  <= std_irq_pkg::RST_PRIORITY[1:0];   // [R6]
      prio_eh <= std_irq_pkg::RST_PRIORITY;        // [R6]
    end else begin
      if (wr_prio_i) begin
        prio_i <= wbyte[1:0];                      // [R3] [R5]
      end
      if (wr_prio_eh) begin
        prio_eh <= wbyte;                          // [R4] [R5]
      end
    end
  end

  // Vector bits; the winner field is owned by hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_msb <= std_irq_pkg::RST_VECTOR;
    end else if (wr_vector) begin
      vector_msb <= wbyte[7:std_irq_pkg::VEC_LSB];
    end
  end

  // Acknowledge clears the channel that won the latched arbitration
  always_comb begin
    ack_clear = 9'h000;
    if (int_ack && arb_valid && (arb_winner <= 4'(std_irq_pkg::I_CHANNEL))) begin
      ack_clear[arb_winner] = 1'b1;                // [R11]
    end
  end

  // One channel slice per interrupt line
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      std_irq_channel u_chan (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .line          (int_lines[gi]),
        .rising_sel    (edge_all[gi]),
        .hold_off      ((gi == std_irq_pkg::I_CHANNEL) ? wr_edge_i : wr_edge_eh),
        .soft_write    ((gi == std_irq_pkg::I_CHANNEL) ? wr_pend_i : wr_pend_eh),
        .soft_value    ((gi == std_irq_pkg::I_CHANNEL) ? wbyte[0] : wbyte[gi % 8]),
        .ack_clear     (ack_clear[gi]),
        .pending       (pending[gi]),
        .overrun       (overrun[gi]),
        .overrun_event (overrun_event[gi])
      );
      // Priority: two software bits above the hardware parity bit
      if (gi == std_irq_pkg::I_CHANNEL) begin : g_prio_i
        assign chan_prio[gi] = {prio_i, 1'b0};                    // [R1] [R2] [R3]
      end else begin : g_prio_eh
        assign chan_prio[gi] = {prio_eh[2*(gi/2)+1], prio_eh[2*(gi/2)], 1'(gi % 2)}; // [R1] [R2] [R4]
      end
    end
  endgenerate

  // Lowest priority value wins; ties go to the lower channel code
  always_comb begin
    best_valid = 1'b0;
    best_code  = std_irq_pkg::RST_WINNER;
    best_prio  = 3'h7;
    for (int i = 0; i < NUM_CH; i++) begin
      if (pending[i] && mask_all[i] && (!best_valid || (chan_prio[i] < best_prio))) begin // [R2] [R11]
        best_valid = 1'b1;
        best_code  = 4'(i);
        best_prio  = chan_prio[i];
      end
    end
  end

  assign int_request = best_valid;                 // [R11]

  // Winner latched once per arbitration cycle; later requests wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arb_winner <= std_irq_pkg::RST_WINNER;
      arb_valid  <= 1'b0;
    end else if (arbitration_cycle_start) begin
      arb_winner <= best_code;                     // [R13]
      arb_valid  <= best_valid;                    // [R13]
    end else if (int_ack) begin
      arb_valid  <= 1'b0;
    end
  end

  // Sticky overrun events, cleared by writing one; a new event wins
  // Written bits sit where they read back: 7:0 are E0..H1, bit 8 is I0,
  // so software can write back what it read to clear exactly those events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 9'h000;
      irq_mask   <= 9'h000;
    end else begin
      irq_status <= (irq_status & ~(wr_status ? hwdata[8:0] : 9'h000)) | overrun_event;
      if (wr_irq_mask) begin
        irq_mask <= hwdata[8:0];
      end
    end
  end

  // Level interrupt while any enabled status bit stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read multiplexer, consecutive channel register indices
  always_comb begin
    rd_value = 8'h00;
    case (ap_index)
      std_irq_pkg::IDX_CHAN_I_MASK:          rd_value = {7'h00, mask_i};                   // [R10]
      std_irq_pkg::IDX_CHAN_E_H_MASK:        rd_value = mask_eh;                           // [R10]
      std_irq_pkg::IDX_CHAN_I_EDGE_SELECT:   rd_value = {7'h00, edge_i};                   // [R10]
      std_irq_pkg::IDX_CHAN_E_H_EDGE_SELECT: rd_value = edge_eh;                           // [R10]
      std_irq_pkg::IDX_CHAN_I_PENDING:       rd_value = {7'h00, pending[8]};               // [R10]
      std_irq_pkg::IDX_CHAN_E_H_PENDING:     rd_value = pending[7:0];                      // [R10]
      std_irq_pkg::IDX_VECTOR_AND_WINNER:    rd_value = {vector_msb, arb_winner, 1'b0};    // [R10]
      std_irq_pkg::IDX_CHAN_I_PRIORITY:      rd_value = {6'h3F, prio_i};                   // [R3] [R10]
      std_irq_pkg::IDX_CHAN_E_H_PRIORITY:    rd_value = prio_eh;                           // [R4] [R10]
      std_irq_pkg::IDX_CHAN_I_OVERRUN:       rd_value = {7'h00, overrun[8]};               // [R9] [R10]
      std_irq_pkg::IDX_CHAN_E_H_OVERRUN:     rd_value = overrun[7:0];                      // [R9] [R10]
      std_irq_pkg::IDX_IRQ_STATUS:           rd_value = irq_status[7:0];
      std_irq_pkg::IDX_IRQ_MASK:             rd_value = irq_mask[7:0];
      default:                               rd_value = 8'h00;
    endcase
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      if (!ap_mapped) begin
        hrdata <= 32'h00000000;
      end else if (ap_index == std_irq_pkg::IDX_IRQ_STATUS) begin
        hrdata <= {23'h000000, irq_status[8], rd_value};
      end else if (ap_index == std_irq_pkg::IDX_IRQ_MASK) begin
        hrdata <= {23'h000000, irq_mask[8], rd_value};
      end else begin
        hrdata <= {24'h000000, rd_value};
      end
    end
  end

endmodule
`default_nettype wire

// file: std_irq_pkg.sv
// Shared constants for the standard interrupt channel block
package std_irq_pkg;

  // Channel count and code widths
  localparam int unsigned NUM_CHANNELS = 9;          // E0..H1 then I0
  localparam int unsigned LOW_CHANNELS = 8;          // Channels held in the low registers
  localparam int unsigned CODE_W       = 4;          // Arbitration winner code width
  localparam int unsigned PRIO_W       = 3;          // Full priority width

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_I_MASK          = 8'hF5;
  localparam logic [7:0] IDX_CHAN_E_H_MASK        = 8'hF6;
  localparam logic [7:0] IDX_CHAN_I_EDGE_SELECT   = 8'hF7;
  localparam logic [7:0] IDX_CHAN_E_H_EDGE_SELECT = 8'hF8;
  localparam logic [7:0] IDX_CHAN_I_PENDING       = 8'hF9;
  localparam logic [7:0] IDX_CHAN_E_H_PENDING     = 8'hFA;
  localparam logic [7:0] IDX_VECTOR_AND_WINNER    = 8'hFB;
  localparam logic [7:0] IDX_CHAN_I_PRIORITY      = 8'hFC;
  localparam logic [7:0] IDX_CHAN_E_H_PRIORITY    = 8'hFD;
  localparam logic [7:0] IDX_CHAN_I_OVERRUN       = 8'hFE;
  localparam logic [7:0] IDX_CHAN_E_H_OVERRUN     = 8'hFF;
  localparam logic [7:0] IDX_IRQ_STATUS           = 8'hF0;
  localparam logic [7:0] IDX_IRQ_MASK             = 8'hF1;

  // Address decode: index sits in byte address bits 9:2
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;

  // Field positions
  localparam int unsigned VEC_LSB    = 5;            // Vector MSBs at 7:5
  localparam int unsigned WIN_LSB    = 1;            // Winner code at 4:1
  localparam int unsigned I_CHANNEL  = 8;            // Channel I0 index and code

  // Reset values
  localparam logic [7:0]        RST_ZERO     = 8'h00;
  localparam logic [7:0]        RST_PRIORITY = 8'hFF;
  localparam logic [2:0]        RST_VECTOR   = 3'h0;
  localparam logic [CODE_W-1:0] RST_WINNER   = 4'hF;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// file: std_irq_channel.sv
`timescale 1ns/1ps
`default_nettype none
// One channel: edge detect, pending bit and overrun flag
module std_irq_channel (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Interrupt source and configuration
  input  wire logic line,          // Interrupt line, synchronous level
  input  wire logic rising_sel,    // 1 rising edge, 0 falling edge
  input  wire logic hold_off,      // Edge-select write in progress
  // Pending bit control
  input  wire logic soft_write,    // Software writes the pending bit
  input  wire logic soft_value,    // Value written
  input  wire logic ack_clear,     // Interrupt acknowledge for this channel
  // State
  output logic      pending,
  output logic      overrun,
  output logic      overrun_event  // Pulse when the flag is newly hit
);

  logic prev_line;   // Line one cycle ago
  logic armed;       // Blocks a false edge in the first cycle after reset
  logic edge_seen;   // Programmed edge in this cycle
  logic next_pending;

  // Edge of the chosen polarity, lost while the edge select is written
  always_comb begin
    if (rising_sel) begin
      edge_seen = armed && !hold_off && line && !prev_line; // [R12]
    end else begin
      edge_seen = armed && !hold_off && !line && prev_line; // [R12]
    end
  end

  // A fresh edge always wins over any clear in the same cycle
  always_comb begin
    if (edge_seen) begin
      next_pending = 1'b1;          // [R11]
    end else if (soft_write) begin
      next_pending = soft_value;
    end else if (ack_clear) begin
      next_pending = 1'b0;          // [R11]
    end else begin
      next_pending = pending;
    end
  end

  assign overrun_event = edge_seen && pending; // [R7] [R8]

  // Line history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_line <= 1'b0;
      armed     <= 1'b0;
    end else begin
      prev_line <= line;
      armed     <= 1'b1;
    end
  end

  // Pending bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

  // Overrun flag follows the pending bit down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun <= 1'b0;                 // [R9]
    end else if (overrun_event) begin
      overrun <= 1'b1;                 // [R7] [R8]
    end else if (pending && !next_pending) begin
      overrun <= 1'b0;                 // [R14]
    end
  end

endmodule
`default_nettype wire

// file: std_irq_prio_overrun_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Checker for priority readback and the arbitration handshake
module std_irq_prio_overrun_sva #(
  parameter int unsigned NUM_CH = 9
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Lines and arbitration
  input wire logic [8:0]  int_lines,
  input wire logic        arbitration_cycle_start,
  input wire logic        int_ack,
  input wire logic        int_request,
  input wire logic [3:0]  arb_winner,
  input wire logic        arb_valid,
  input wire logic        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       ph_v;   // Data phase of a taken, mapped transfer
  logic       ph_wr;  // That transfer is a write
  logic [7:0] ph_idx; // Its register index
  logic [7:0] sh_l;   // Software copy of the pair E..H priorities
  logic [1:0] sh_i;   // Software copy of the pair I priority

  // Address phase capture; misaligned or high addresses never match a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_v   <= 1'b0;
      ph_wr  <= 1'b0;
      ph_idx <= 8'h00;
    end else begin
      ph_v   <= hsel && hready && htrans == std_irq_pkg::HTRANS_NONSEQ && haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
      ph_wr  <= hwrite;
      ph_idx <= haddr[9:2];
    end
  end

  // Only bus writes may change the copies, which start at all ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_l <= 8'hFF;
      sh_i <= 2'h3;
    end else if (ph_v && ph_wr && ph_idx == std_irq_pkg::IDX_CHAN_E_H_PRIORITY) begin
      sh_l <= hwdata[7:0];
    end else if (ph_v && ph_wr && ph_idx == std_irq_pkg::IDX_CHAN_I_PRIORITY) begin
      sh_i <= hwdata[1:0];
    end
  end

  // Read data reflects the register before a write landing at the same edge
  property p_prio_low_read;
    ph_v && !ph_wr && ph_idx == std_irq_pkg::IDX_CHAN_E_H_PRIORITY |-> hrdata[7:0] == $past(sh_l);
  endproperty
  a_prio_low_read: assert property (p_prio_low_read) else $error("low priority readback wrong");
  property p_prio_high_read;
    ph_v && !ph_wr && ph_idx == std_irq_pkg::IDX_CHAN_I_PRIORITY |-> hrdata[7:0] == {6'h3F, $past(sh_i)};
  endproperty
  a_prio_high_read: assert property (p_prio_high_read) else $error("high priority readback wrong");
  property p_winner_hold;
    $changed(arb_winner) |-> $past(arbitration_cycle_start);
  endproperty
  a_winner_hold: assert property (p_winner_hold) else $error("winner changed mid cycle");
  property p_valid_cause;
    arbitration_cycle_start |=> arb_valid == $past(int_request);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid not tied to request");
  property p_idle_code;
    arbitration_cycle_start && !int_request |=> arb_winner == 4'hF;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("idle winner code wrong");
  property p_code_range;
    arb_valid |-> {28'h0, arb_winner} < NUM_CH;
  endproperty
  a_code_range: assert property (p_code_range) else $error("winner code out of range");
  property p_ack_drop;
    int_ack && !arbitration_cycle_start |=> !arb_valid;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("valid kept after acknowledge");
  property p_valid_hold;
    !arbitration_cycle_start && !int_ack |=> $stable(arb_valid);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid moved without cause");
endmodule

bind std_irq_prio_overrun std_irq_prio_overrun_sva #(.NUM_CH(NUM_CH)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .int_lines(int_lines), .arbitration_cycle_start(arbitration_cycle_start),
  .int_ack(int_ack), .int_request(int_request), .arb_winner(arb_winner), .arb_valid(arb_valid), .irq(irq));
`default_nettype wire

// file: cpu_arb_model.sv
`timescale 1ns/1ps
`default_nettype none
// CPU side: opens arbitration cycles and acknowledges the winner
module cpu_arb_model (
  // Clock and control
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       enable,
  input wire logic       slow,
  // From the block
  input wire logic       int_request,
  input wire logic       arb_valid,
  input wire logic [3:0] arb_winner,
  // To the block and bench
  output logic           arbitration_cycle_start,
  output logic           int_ack,
  output logic           taken_stb,
  output logic [3:0]     taken
);
  // Cycles open even with nothing pending, so the empty code is seen too
  initial begin
    arbitration_cycle_start = 1'b0;
    int_ack = 1'b0;
    taken_stb = 1'b0;
    taken = 4'h0;
    forever begin
      @(posedge hclk);
      if (hresetn && enable) begin
        arbitration_cycle_start <= 1'b1;
        @(posedge hclk);
        arbitration_cycle_start <= 1'b0;
        // Slow service leaves the code standing for several cycles
        repeat (slow ? 6 : 1) @(posedge hclk);
        int_ack <= arb_valid;
        taken_stb <= arb_valid;
        taken <= arb_winner;
        @(posedge hclk);
        int_ack <= 1'b0;
        taken_stb <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: std_irq_channel_priority_overrun_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module std_irq_channel_priority_overrun_tb_top;
  // Bus and line stimulus
  logic        hclk, hresetn, hsel, hwrite, hready, en, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  int_lines;
  // Block outputs and CPU handshake
  logic        hreadyout, hresp, int_request, arb_valid, irq, acs, int_ack, taken_stb;
  logic [3:0]  arb_winner, taken;
  int          err_total, n_compared;
  // Grant order for pairs E=2 F=3 G=0 H=3 and pair I=1
  logic [3:0]  order [9] = '{4'h4, 4'h5, 4'h8, 4'h0, 4'h1, 4'h2, 4'h6, 4'h3, 4'h7};
  // Reset values of indices F5 to FF
  logic [7:0]  rst_val [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1E, 8'hFF, 8'hFF, 8'h00, 8'h00};

  assign hready = hreadyout; // Single slave drives bus ready

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  std_irq_prio_overrun dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .int_lines(int_lines), .arbitration_cycle_start(acs), .int_ack(int_ack),
    .int_request(int_request), .arb_winner(arb_winner), .arb_valid(arb_valid), .irq(irq));

  cpu_arb_model cpu (.hclk(hclk), .hresetn(hresetn), .enable(en), .slow(slow), .int_request(int_request),
    .arb_valid(arb_valid), .arb_winner(arb_winner), .arbitration_cycle_start(acs), .int_ack(int_ack),
    .taken_stb(taken_stb), .taken(taken));

  task stop_test;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits for ready at a rising edge; a hung slave ends the run
  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 16) begin
        err_total++;
        stop_test;
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; read data taken at the data phase edge
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= std_irq_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task rdc(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    check(rd, e);
  endtask

  task wait_taken;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (taken_stb !== 1'b1 && n < 40);
    if (taken_stb !== 1'b1) begin
      err_total++;
      stop_test;
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    int_lines = 9'h000;
    en = 1'b0;
    slow = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped read, priority and read-only overrun access
    for (int i = 0; i < 11; i++) rdc(8'hF5 + 8'(i), {24'h0, rst_val[i]});
    rdc(8'h10, 32'h0);
    check({30'h0, hresp, hreadyout}, 32'h1);
    wr(8'hFB, 32'hFF);
    rdc(8'hFB, 32'hFE);
    wr(8'hFD, 32'hCE);
    rdc(8'hFD, 32'hCE);
    wr(8'hFC, 32'h01);
    rdc(8'hFC, 32'hFD);
    wr(8'hFE, 32'hFF);
    wr(8'hFF, 32'hFF);
    rdc(8'hFE, 32'h0);
    rdc(8'hFF, 32'h0);
    // Pairs E,F rising, G,H falling, I rising; wrong edges first
    wr(8'hF8, 32'h0F);
    wr(8'hF7, 32'h01);
    int_lines <= 9'h0F0;
    repeat (3) @(posedge hclk);
    rdc(8'hFA, 32'h0);
    int_lines <= 9'h10F;
    repeat (3) @(posedge hclk);
    rdc(8'hFA, 32'hFF);
    rdc(8'hF9, 32'h01);
    rdc(8'hFF, 32'h0);
    // Second trigger while still pending raises every overrun flag
    int_lines <= 9'h0F0;
    repeat (2) @(posedge hclk);
    int_lines <= 9'h10F;
    repeat (3) @(posedge hclk);
    rdc(8'hFF, 32'hFF);
    rdc(8'hFE, 32'h01);
    rdc(8'hF0, 32'h1FF);
    check({31'h0, irq}, 32'h0);
    wr(8'hF1, 32'h1FF);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    rdc(8'hF1, 32'h1FF);
    wr(8'hF0, 32'h1FF);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    rdc(8'hF0, 32'h0);
    // Masks gate the request, then all nine are served by priority
    check({31'h0, int_request}, 32'h0);
    wr(8'hF6, 32'hFF);
    wr(8'hF5, 32'h01);
    check({31'h0, int_request}, 32'h1);
    en <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      slow <= (k < 3);
      wait_taken;
      check({28'h0, taken}, {28'h0, order[k]});
    end
    repeat (6) @(posedge hclk);
    check({27'h0, arb_valid, arb_winner}, 32'h0F);
    en <= 1'b0;
    // Acknowledge cleared pending bits and their overrun flags
    rdc(8'hFA, 32'h0);
    rdc(8'hF9, 32'h0);
    rdc(8'hFF, 32'h0);
    rdc(8'hFE, 32'h0);
    wr(8'hFA, 32'h01);
    rdc(8'hFA, 32'h01);
    stop_test;
  end
endmodule
`default_nettype wire
